// ---- logic/option_defs.svh ----
/*
 * constants of the startup option and lock bits block: field positions,
 * erased values, read addresses and clock source codes.
 * assumes it is included by bare name wherever these macros are used.
 */
// What this block does
// - option bytes latched at start, software cannot change
// - cpu reads both bytes by data-space reads
// - byte0 bit6 set frees reset pin
// - byte0 bit5 picks port reset level
// - byte0 bit4 picks brownout threshold 3.8V/2.5V
// - byte0 bit2 enables input clock filter
// - byte0 bits1:0 pick cpu clock source
// - byte1 bit5 picks rc 10MHz/20MHz, default 20MHz
// - code lock zero blocks code and options
// - data lock zero blocks data and options
// - both locks one allow everything
// - code lock only: data open, bank erase ignored
// - both locks zero block all reads
// - programming mode floats all pwm pins
// - port reset level sets pwm start level
`ifndef OPTION_DEFS_SVH
`define OPTION_DEFS_SVH

// ****************************************
// field positions of option byte zero
// ****************************************
`define OPT0_RESET_PIN_BIT 6
`define OPT0_PORT_LEVEL_BIT 5
`define OPT0_BROWNOUT_BIT 4
`define OPT0_FILTER_BIT 2
`define OPT0_OSC_HI_BIT 1
`define OPT0_OSC_LO_BIT 0

// ****************************************
// field positions of option byte one
// ****************************************
`define OPT1_CODE_LOCK_BIT 7
`define OPT1_DATA_LOCK_BIT 6
`define OPT1_RC_FREQ_BIT 5

// ****************************************
// erased values and read addresses
// ****************************************
`define OPT_ERASED_VALUE 8'hFF
`define OPT0_XDATA_ADDR 16'hFFF0
`define OPT1_XDATA_ADDR 16'hFFF1
`define OPT_ZERO_BYTE 8'h00

// ****************************************
// clock source codes
// ****************************************
`define OSC_CRYSTAL 2'h0
`define OSC_INTERNAL_RC 2'h1
`define OSC_RESERVED 2'h2
`define OSC_EXT_CLOCK_PIN 2'h3

`endif

// ---- logic/option_pkg.sv ----
/*
 * types of the startup option and lock bits block.
 * assumes option_defs.svh holds the numeric constants.
 */
package option_pkg;

    // programmer request codes
    typedef enum logic [2:0] {
        OP_READ_CODE,
        OP_PROG_CODE,
        OP_READ_DATA,
        OP_PROG_DATA,
        OP_BANK_ERASE,
        OP_READ_OPTION,
        OP_PROG_OPTION,
        OP_NONE
    } prog_op_e;

    // start-up sequence
    typedef enum logic [0:0] {
        ST_LOAD,
        ST_RUN
    } boot_state_e;

endpackage

// ---- logic/startup_option_and_lock_bits.sv ----
/*
 * startup option and lock bits: latches the two stored option bytes once
 * after reset, decodes them into the chip's configuration levels, serves
 * cpu data-space reads of both bytes, gates every programmer request
 * against the lock bits and handles the pwm pins at start and in
 * programming mode.
 * assumes the flash array presents the stored option bytes steadily on
 * opt0_nv_in / opt1_nv_in, and that all inputs are synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "option_defs.svh"

module startup_option_and_lock_bits (
    input wire logic clk_in, // 100 MHz clock
    input wire logic rstn_in, // async reset, active low
    input wire logic [7:0] opt0_nv_in, // stored option byte zero
    input wire logic [7:0] opt1_nv_in, // stored option byte one
    input wire logic xdata_rd_in, // cpu data-space read strobe
    input wire logic [15:0] xdata_addr_in, // cpu data-space address
    output logic [7:0] xdata_rd_data_out, // read data, next cycle
    output logic xdata_rd_hit_out, // read hit an option byte
    input wire logic prog_req_in, // programmer request strobe
    input wire logic [2:0] prog_op_in, // programmer request code
    input wire logic prog_opt_sel_in, // option byte select, 1 = byte one
    output logic prog_grant_out, // request allowed, one cycle
    output logic prog_deny_out, // request refused, one cycle
    output logic [7:0] prog_rd_data_out, // option byte on allowed read
    input wire logic in_circuit_programming_mode_in, // programming mode active
    input wire logic [3:0] pwm_level_in, // levels from pwm generator
    input wire logic pwm_run_in, // pwm generator running
    output logic [3:0] pwm_pin_out, // pwm pin levels
    output logic [3:0] pwm_pin_oe_out, // pwm pin drive enables
    output logic options_valid_out, // latched options valid
    output logic startup_option_byte_out_unused, // constant low
    output logic reset_pin_disable_out, // reset pin used as input
    output logic port_reset_level_high_out, // ports reset high
    output logic brownout_threshold_select_out, // 1 = 2.5V, 0 = 3.8V
    output logic clock_filter_enable_out, // input clock filter on
    output logic osc_source_sel_hi_out, // clock source code bit 1
    output logic osc_source_sel_lo_out, // clock source code bit 0
    output logic rc_freq_select_out, // 1 = 20MHz, 0 = 10MHz
    output logic code_area_lock_out, // 0 = code area locked
    output logic data_area_lock_out // 0 = data area locked
);

    // ****************************************
    // state of the block
    // ****************************************
    typedef struct packed {
        option_pkg::boot_state_e state;
        logic [7:0] opt0;
        logic [7:0] opt1;
        logic [7:0] xdata_data;
        logic xdata_hit;
        logic grant;
        logic deny;
        logic [7:0] prog_data;
        logic pwm_started;
    } option_state_s;

    option_state_s cur_ff;
    option_state_s nxt_ff;

    // ****************************************
    // permission decode
    // ****************************************

    // decides whether a request is allowed for a pair of lock bits
    function automatic logic allowed(
        input logic [2:0] op,
        input logic code_open,
        input logic data_open
    );
        logic ok;
        ok = 1'b0;
        if (code_open && data_open) begin
            ok = (op != option_pkg::OP_NONE);
        end else if (!code_open && data_open) begin
            ok = (op == option_pkg::OP_READ_DATA) || (op == option_pkg::OP_PROG_DATA);
        end else if (!code_open && !data_open) begin
            ok = (op == option_pkg::OP_BANK_ERASE);
        end else begin
            // unsupported combination: everything refused
            ok = 1'b0;
        end
        return ok;
    endfunction

    // live lock bits: a lock takes hold as soon as it is programmed
    logic code_open;
    logic data_open;
    logic req_ok;
    assign code_open = opt1_nv_in[`OPT1_CODE_LOCK_BIT];
    assign data_open = opt1_nv_in[`OPT1_DATA_LOCK_BIT];
    assign req_ok = allowed(prog_op_in, code_open, data_open);

    // ****************************************
    // next state
    // ****************************************

    // one-shot latch, reads, request gating, pwm start
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.grant = 1'b0;
        nxt_ff.deny = 1'b0;
        nxt_ff.xdata_hit = 1'b0;

        // latch once after reset, never again
        unique case (cur_ff.state)
            option_pkg::ST_LOAD: begin
                nxt_ff.opt0 = opt0_nv_in;
                nxt_ff.opt1 = opt1_nv_in;
                nxt_ff.state = option_pkg::ST_RUN;
            end
            option_pkg::ST_RUN: begin
                nxt_ff.state = option_pkg::ST_RUN;
            end
        endcase

        // cpu data-space reads of the latched bytes
        if (xdata_rd_in && cur_ff.state == option_pkg::ST_RUN) begin
            if (xdata_addr_in == `OPT0_XDATA_ADDR) begin
                nxt_ff.xdata_data = cur_ff.opt0;
                nxt_ff.xdata_hit = 1'b1;
            end else if (xdata_addr_in == `OPT1_XDATA_ADDR) begin
                nxt_ff.xdata_data = cur_ff.opt1;
                nxt_ff.xdata_hit = 1'b1;
            end else begin
                nxt_ff.xdata_data = `OPT_ZERO_BYTE;
            end
        end

        // programmer requests checked against the lock bits
        if (prog_req_in) begin
            nxt_ff.grant = req_ok;
            nxt_ff.deny = !req_ok;
            if (req_ok && prog_op_in == option_pkg::OP_READ_OPTION) begin
                nxt_ff.prog_data = prog_opt_sel_in ? opt1_nv_in : opt0_nv_in;
            end else begin
                nxt_ff.prog_data = `OPT_ZERO_BYTE;
            end
        end

        // pwm pins hold the reset level until the generator first runs
        if (pwm_run_in && !in_circuit_programming_mode_in) begin
            nxt_ff.pwm_started = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************

    // erased values until the first load
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur_ff.state <= option_pkg::ST_LOAD;
            cur_ff.opt0 <= `OPT_ERASED_VALUE;
            cur_ff.opt1 <= `OPT_ERASED_VALUE;
            cur_ff.xdata_data <= `OPT_ZERO_BYTE;
            cur_ff.xdata_hit <= 1'b0;
            cur_ff.grant <= 1'b0;
            cur_ff.deny <= 1'b0;
            cur_ff.prog_data <= `OPT_ZERO_BYTE;
            cur_ff.pwm_started <= 1'b0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // read and request answers
    assign xdata_rd_data_out = cur_ff.xdata_data;
    assign xdata_rd_hit_out = cur_ff.xdata_hit;
    assign prog_grant_out = cur_ff.grant;
    assign prog_deny_out = cur_ff.deny;
    assign prog_rd_data_out = cur_ff.prog_data;
    assign options_valid_out = (cur_ff.state == option_pkg::ST_RUN);
    assign startup_option_byte_out_unused = 1'b0;

    // decoded configuration levels from the latched bytes
    assign reset_pin_disable_out = cur_ff.opt0[`OPT0_RESET_PIN_BIT];
    assign port_reset_level_high_out = cur_ff.opt0[`OPT0_PORT_LEVEL_BIT];
    assign brownout_threshold_select_out = cur_ff.opt0[`OPT0_BROWNOUT_BIT];
    assign clock_filter_enable_out = cur_ff.opt0[`OPT0_FILTER_BIT];
    assign osc_source_sel_hi_out = cur_ff.opt0[`OPT0_OSC_HI_BIT];
    assign osc_source_sel_lo_out = cur_ff.opt0[`OPT0_OSC_LO_BIT];
    assign rc_freq_select_out = cur_ff.opt1[`OPT1_RC_FREQ_BIT];
    assign code_area_lock_out = cur_ff.opt1[`OPT1_CODE_LOCK_BIT];
    assign data_area_lock_out = cur_ff.opt1[`OPT1_DATA_LOCK_BIT];

    // pwm pins: start level from the port level bit, float in programming
    assign pwm_pin_out = cur_ff.pwm_started ? pwm_level_in
        : {4{cur_ff.opt0[`OPT0_PORT_LEVEL_BIT]}};
    assign pwm_pin_oe_out = in_circuit_programming_mode_in ? 4'h0 : 4'hF;

endmodule // startup_option_and_lock_bits
`default_nettype wire

// ---- bench/option_lock_monitor.sv ----
/* checker of the option block: programmer gating, cpu hits, pwm float.
   assumes it is bound onto the option block */
`timescale 1ns/1ps
`default_nettype none
module option_lock_monitor (
    input wire logic clk_in, // clock
    input wire logic rstn_in, // reset, low
    input wire logic [7:0] opt1_nv_in, // stored byte one
    input wire logic xdata_rd_in, // cpu read
    input wire logic [15:0] xdata_addr_in, // cpu address
    input wire logic xdata_rd_hit_out, // read hit
    input wire logic prog_req_in, // request
    input wire logic [2:0] prog_op_in, // request code
    input wire logic prog_grant_out, // allowed
    input wire logic prog_deny_out, // refused
    input wire logic in_circuit_programming_mode_in, // prog mode
    input wire logic [3:0] pwm_pin_oe_out, // pwm enables
    input wire logic options_valid_out // latched
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // live lock pair and option read decode
    wire logic [1:0] lk = opt1_nv_in[7:6];
    wire logic cpu_opt = xdata_rd_in && options_valid_out && xdata_addr_in[15:1] == 15'h7FF8;
    one_answer_a: assert property (prog_req_in |=> prog_grant_out ^ prog_deny_out)
        else $error("no single answer");
    code_lock_a: assert property (prog_req_in && !lk[1] && prog_op_in == 3'h0 |=> prog_deny_out)
        else $error("code read let through");
    data_lock_a: assert property (prog_req_in && !lk[0] && prog_op_in == 3'h2 |=> prog_deny_out)
        else $error("data read let through");
    all_open_a: assert property (prog_req_in && lk == 2'h3 && prog_op_in != 3'h7 |=> prog_grant_out)
        else $error("open request refused");
    data_open_a: assert property (prog_req_in && lk == 2'h1 && prog_op_in[2:1] == 2'h1 |=> prog_grant_out)
        else $error("data request refused");
    erase_ignored_a: assert property (prog_req_in && lk == 2'h1 && prog_op_in == 3'h4 |=> prog_deny_out)
        else $error("bank erase let through");
    cpu_hit_a: assert property (cpu_opt |=> xdata_rd_hit_out)
        else $error("option read missed");
    pwm_float_a: assert property (in_circuit_programming_mode_in |-> pwm_pin_oe_out == 4'h0)
        else $error("pwm driven in prog mode");
endmodule // option_lock_monitor
bind startup_option_and_lock_bits option_lock_monitor u_mon (.clk_in, .rstn_in, .opt1_nv_in, .xdata_rd_in,
    .xdata_addr_in, .xdata_rd_hit_out, .prog_req_in, .prog_op_in, .prog_grant_out, .prog_deny_out,
    .in_circuit_programming_mode_in, .pwm_pin_oe_out, .options_valid_out);
`default_nettype wire

// ---- bench/opt_writer.sv ----
/* programmer model: erases and programs both option bytes, makes requests.
   assumes the bench clock on clk_in */
`timescale 1ns/1ps
`default_nettype none
module opt_writer (
    input wire logic clk_in, // bench clock
    output logic prog_req_out, // request strobe
    output logic [2:0] prog_op_out, // request code
    output logic prog_sel_out, // option byte select
    output logic [7:0] opt0_nv_out, // stored byte zero
    output logic [7:0] opt1_nv_out // stored byte one
);
    // erased flash, idle request line
    initial begin
        prog_req_out = 1'b0;
        prog_op_out = 3'h7;
        prog_sel_out = 1'b0;
        opt0_nv_out = 8'hFF;
        opt1_nv_out = 8'hFF;
    end
    // erase and program in one step, reserved bits high
    task automatic store(input logic [7:0] b0, input logic [7:0] b1);
        @(posedge clk_in);
        #1 opt0_nv_out = b0 | 8'h88;
        opt1_nv_out = b1 | 8'h1F;
    endtask
    // one-cycle strobe, code scrambled once released
    task automatic request(input logic [2:0] op, input logic sel);
        @(posedge clk_in);
        #1 prog_req_out = 1'b1;
        prog_op_out = op;
        prog_sel_out = sel;
        @(posedge clk_in);
        #1 prog_req_out = 1'b0;
        prog_op_out = ~op;
    endtask
endmodule // opt_writer
`default_nettype wire

// ---- bench/startup_option_and_lock_bits_tb_top.sv ----
/* bench of the option block: lock rows, latching, cpu reads, pwm pins.
   assumes the programmer model drives stored bytes and requests */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
$display("wrong value %s expected %h seen %h", what, exp, got); end end
module startup_option_and_lock_bits_tb_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic xdata_rd_in = 1'b0;
    logic [15:0] xdata_addr_in = 16'h0000;
    logic in_circuit_programming_mode_in = 1'b0;
    logic [3:0] pwm_level_in = 4'h0;
    logic pwm_run_in = 1'b0;
    logic req, sel, grant, deny, hit, valid, rc;
    logic [2:0] op;
    logic [7:0] nv0, nv1, rd, pd, b0;
    logic [3:0] pin, oe;
    wire logic [5:0] d0;
    wire logic [1:0] lk;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    // grant mask per lock pair, index {code lock, data lock}
    logic [7:0] allow [4] = '{8'h10, 8'h0C, 8'h00, 8'h7F};
    opt_writer u_opt_writer (.clk_in, .prog_req_out(req), .prog_op_out(op), .prog_sel_out(sel),
        .opt0_nv_out(nv0), .opt1_nv_out(nv1));
    startup_option_and_lock_bits u_startup_option_and_lock_bits (.clk_in, .rstn_in, .opt0_nv_in(nv0),
        .opt1_nv_in(nv1), .xdata_rd_in, .xdata_addr_in, .xdata_rd_data_out(rd), .xdata_rd_hit_out(hit),
        .prog_req_in(req), .prog_op_in(op), .prog_opt_sel_in(sel), .prog_grant_out(grant),
        .prog_deny_out(deny), .prog_rd_data_out(pd), .in_circuit_programming_mode_in, .pwm_level_in,
        .pwm_run_in, .pwm_pin_out(pin), .pwm_pin_oe_out(oe), .options_valid_out(valid),
        .startup_option_byte_out_unused(), .reset_pin_disable_out(d0[5]), .port_reset_level_high_out(d0[4]),
        .brownout_threshold_select_out(d0[3]), .clock_filter_enable_out(d0[2]),
        .osc_source_sel_hi_out(d0[1]), .osc_source_sel_lo_out(d0[0]), .rc_freq_select_out(rc),
        .code_area_lock_out(lk[1]), .data_area_lock_out(lk[0]));
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reset pulse, returns after the latching edge
    task automatic do_reset(input int n);
        @(posedge clk_in);
        #1 rstn_in = 1'b0;
        repeat (n) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        @(posedge clk_in);
        #1;
    endtask
    // one cpu read strobe
    task automatic cpu_read(input logic [15:0] a);
        @(posedge clk_in);
        #1 xdata_rd_in = 1'b1;
        xdata_addr_in = a;
        @(posedge clk_in);
        #1 xdata_rd_in = 1'b0;
    endtask
    // clock and hang limit
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude();
        end
    end
    // main sequence
    initial begin
        do_reset(16);
        for (int r = 0; r < 4; r++) begin
            u_opt_writer.store(8'hFF, {r[1:0], 6'h3F});
            for (int k = 0; k < 8; k++) begin
                u_opt_writer.request(k[2:0], 1'b0);
                `CHECK("grant", allow[r][k], grant)
                `CHECK("deny", ~allow[r][k], deny)
            end
        end
        for (int i = 0; i < 4; i++) begin
            b0 = {1'b1, i[0], ~i[0], i[1], 1'b1, i[1], i[1:0]};
            u_opt_writer.store(b0, {2'h3, i[0], 5'h1F});
            do_reset(2);
            `CHECK("fields", {b0[6:4], b0[2:0]}, d0)
            `CHECK("rc", i[0], rc)
            `CHECK("valid", 1'b1, valid)
            `CHECK("locks", 2'h3, lk)
            `CHECK("pwm start", {4{b0[5]}}, pin)
            u_opt_writer.request(3'h5, i[1]);
            `CHECK("option read", i[1] ? {2'h3, i[0], 5'h1F} : b0, pd)
            cpu_read(16'hFFF0 | i[0]);
            `CHECK("cpu read", {1'b1, i[0] ? 8'hFF : b0}, {hit, rd})
        end
        u_opt_writer.store(8'h88, 8'h1F);
        cpu_read(16'hFFF2);
        `CHECK("miss", 9'h000, {hit, rd})
        `CHECK("held fields", {b0[6:4], b0[2:0]}, d0)
        `CHECK("held locks", 2'h3, lk)
        pwm_level_in = 4'hA;
        pwm_run_in = 1'b1;
        @(posedge clk_in);
        #1 `CHECK("pwm run", 4'hA, pin)
        in_circuit_programming_mode_in = 1'b1;
        #1 `CHECK("pwm float", 4'h0, oe)
        repeat (2) @(posedge clk_in);
        conclude();
    end
endmodule // startup_option_and_lock_bits_tb_top
`default_nettype wire
